// ### rtl/rls_survey_ctrl.sv
// Contract
// - A survey starts on a write of code 0x20 in bits 15:8 of the command word with a node number in bits 7:0.
// - Only node numbers 1 to 15 start a survey of that node with the gateway.
// - Code 0x20 with node number zero stops any running survey.
// - At most one node is surveyed at a time; a start while running is ignored.
// - While surveying, the gateway's own error messages are ignored.
// - While surveying, registers 7 and 8 read the survey totals instead of their normal contents.
// - Register 7 holds poor in 15:8 and missed in 7:0; register 8 holds excellent and good.
// - Each transmit and receive interval yields the weakest strength seen as its sample.
// - The four totals are a sliding tally over the latest 100 samples.
// - Every sample falls into exactly one of excellent, good, poor or missed.
// - Register 8 is saved when a survey starts and restored when it stops.
// - While surveying, green, amber and red indicators show excellent, good and poor.
// - A legacy layout swaps the byte halves of both result registers.
`timescale 1ns/1ps
`include "rls_defs.svh"
module rls_survey_ctrl #(
   parameter int         WIN      = `RLS_WINDOW_LEN,
   parameter logic [7:0] EXC_MIN  = `RLS_EXC_MIN,
   parameter logic [7:0] GOOD_MIN = `RLS_GOOD_MIN
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Holding register access
   input  wire logic              hr_wr_en,
   input  wire rls_pkg::rls_hreg_t hr_wr,
   input  wire logic              hr_rd_en,
   input  wire logic [4:0]        hr_rd_addr,
   output logic      [15:0]       hr_rd_data,
   output logic                   hr_rd_valid,
   // Radio link measurements
   input  wire logic              rssi_valid,
   input  wire logic [7:0]        rssi_level,
   input  wire logic              interval_end,
   // Gateway error messages
   input  wire logic              err_valid,
   input  wire logic [15:0]       err_code,
   // Layout strap
   input  wire logic              legacy_layout,
   // Status and indicators
   output logic                   survey_active,
   output logic      [3:0]        survey_node,
   output logic                   led_green,
   output logic                   led_amber,
   output logic                   led_red
);
   import rls_pkg::*;

   localparam int AW = $clog2(WIN);
   localparam int CW = $clog2(WIN + 1);
   localparam logic [AW-1:0] LAST_PTR = AW'(WIN - 1);
   localparam logic [CW-1:0] WIN_CNT  = CW'(WIN);

   function automatic rls_cat_t classify(input logic missed, input logic [7:0] lvl);
      if (missed) begin
         return RLS_CAT_MISSED;
      end else if (lvl >= EXC_MIN) begin
         return RLS_CAT_EXC;
      end else if (lvl >= GOOD_MIN) begin
         return RLS_CAT_GOOD;
      end
      return RLS_CAT_POOR;
   endfunction

   function automatic logic [7:0] tally_byte(input logic [CW-1:0] c);
      return 8'(c);
   endfunction

   rls_state_t       state;
   rls_state_t       next_state;
   logic [15:0]      cmd_word;
   logic [15:0]      norm7;
   logic [15:0]      norm8;
   logic [15:0]      saved8;
   logic             have_rx;
   logic [7:0]       min_lvl;
   logic             samp_go;
   rls_cat_t         samp_cat;
   logic             upd_go;
   rls_cat_t         upd_cat;
   logic [AW-1:0]    upd_ptr;
   logic [AW-1:0]    ptr;
   logic [CW-1:0]    fill;
   logic [CW-1:0]    cnt [4];
   logic [1:0]       old_bits;

   // Command decode
   wire       cmd_wr    = hr_wr_en && (hr_wr.addr == `RLS_IO_COMMAND);
   wire [7:0] cmd_code  = hr_wr.data[`RLS_CODE_HI:`RLS_CODE_LO];
   wire [7:0] cmd_node  = hr_wr.data[`RLS_DATA_HI:`RLS_DATA_LO];
   wire       survey_wr = cmd_wr && (cmd_code == `RLS_CODE_SURVEY);
   wire       running   = (state == RLS_ST_RUN);
   wire       node_ok   = (cmd_node != `RLS_NODE_STOP) && (cmd_node <= `RLS_NODE_MAX);
   wire       start     = survey_wr && node_ok && !running;
   wire       stop      = survey_wr && (cmd_node == `RLS_NODE_STOP) && running;
   wire       kill      = start || stop;

   // Weakest level of the interval, counting a level that arrives with its end
   wire       eff_have  = have_rx || rssi_valid;
   wire [7:0] eff_min   = (!have_rx || (rssi_valid && rssi_level < min_lvl)) ?
                          rssi_level : min_lvl;
   wire rls_cat_t next_cat = classify(!eff_have, eff_min);

   // Tally update
   wire       full      = (fill == WIN_CNT);
   wire rls_cat_t old_cat = rls_cat_t'(old_bits);
   wire [AW-1:0] next_ptr = (ptr == LAST_PTR) ? '0 : ptr + 1'b1;

   // Result words in either layout
   wire [7:0]  poor_b   = tally_byte(cnt[RLS_CAT_POOR]);
   wire [7:0]  miss_b   = tally_byte(cnt[RLS_CAT_MISSED]);
   wire [7:0]  exc_b    = tally_byte(cnt[RLS_CAT_EXC]);
   wire [7:0]  good_b   = tally_byte(cnt[RLS_CAT_GOOD]);
   wire [15:0] word7    = legacy_layout ? {miss_b, poor_b} : {poor_b, miss_b};
   wire [15:0] word8    = legacy_layout ? {good_b, exc_b} : {exc_b, good_b};
   wire [15:0] view7    = running ? word7 : norm7;
   wire [15:0] view8    = running ? word8 : norm8;
   wire [15:0] rd_mux   = (hr_rd_addr == `RLS_IO_POOR_MISSED) ? view7 :
                          (hr_rd_addr == `RLS_IO_EXC_GOOD)    ? view8 :
                          (hr_rd_addr == `RLS_IO_COMMAND)     ? cmd_word :
                          `RLS_UNMAPPED_DATA;

   always_comb begin
      next_state = state;
      unique case (state)
         RLS_ST_IDLE: begin
            if (start) begin
               next_state = RLS_ST_RUN;
            end
         end
         RLS_ST_RUN: begin
            if (stop) begin
               next_state = RLS_ST_IDLE;
            end
         end
         default: begin
            next_state = RLS_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state         <= RLS_ST_IDLE;
         survey_active <= 1'b0;
         survey_node   <= 4'h0;
      end else begin
         state         <= next_state;
         survey_active <= (next_state == RLS_ST_RUN);
         if (start) begin
            survey_node <= cmd_node[3:0];
         end else if (stop) begin
            survey_node <= 4'h0;
         end
      end
   end

   // Command word keeps whatever the host wrote
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmd_word <= `RLS_CMD_RESET;
      end else if (cmd_wr) begin
         cmd_word <= hr_wr.data;
      end
   end

   // Normal contents; frozen while surveying so the saved copy stays true
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         norm7  <= `RLS_NORM_RESET;
         norm8  <= `RLS_NORM_RESET;
         saved8 <= `RLS_NORM_RESET;
      end else begin
         if (hr_wr_en && hr_wr.addr == `RLS_IO_POOR_MISSED && !running) begin
            norm7 <= hr_wr.data;
         end
         if (start) begin
            saved8 <= norm8;
         end
         if (stop) begin
            norm8 <= saved8;
         end else if (hr_wr_en && hr_wr.addr == `RLS_IO_EXC_GOOD && !running) begin
            norm8 <= hr_wr.data;
         end else if (err_valid && !running) begin
            norm8 <= err_code;
         end
      end
   end

   // Weakest level per interval
   always_ff @(posedge clk) begin
      if (sys_rst || interval_end || start) begin
         have_rx <= 1'b0;
         min_lvl <= 8'h00;
      end else if (rssi_valid) begin
         have_rx <= 1'b1;
         min_lvl <= eff_min;
      end
   end

   // Sample pipeline: read the oldest entry, then update and overwrite it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         samp_go  <= 1'b0;
         samp_cat <= RLS_CAT_MISSED;
         upd_go   <= 1'b0;
         upd_cat  <= RLS_CAT_MISSED;
         upd_ptr  <= '0;
         ptr      <= '0;
      end else begin
         samp_go  <= interval_end && running && !kill;
         samp_cat <= next_cat;
         upd_go   <= samp_go && !kill;
         upd_cat  <= samp_cat;
         upd_ptr  <= ptr;
         if (start) begin
            ptr <= '0;
         end else if (samp_go) begin
            ptr <= next_ptr;
         end
      end
   end

   // Totals: add the new sample and drop the one leaving the window
   always_ff @(posedge clk) begin
      if (sys_rst || start) begin
         fill <= '0;
         for (int i = 0; i < 4; i++) begin
            cnt[i] <= '0;
         end
      end else if (upd_go && !kill) begin
         if (!full) begin
            fill <= fill + 1'b1;
         end
         for (int i = 0; i < 4; i++) begin
            cnt[i] <= cnt[i] + CW'(upd_cat == rls_cat_t'(i))
                             - CW'(full && old_cat == rls_cat_t'(i));
         end
      end
   end

   // Indicators follow the latest sample; missed lights none
   always_ff @(posedge clk) begin
      if (sys_rst || !running || kill) begin
         led_green <= 1'b0;
         led_amber <= 1'b0;
         led_red   <= 1'b0;
      end else if (upd_go) begin
         led_green <= (upd_cat == RLS_CAT_EXC);
         led_amber <= (upd_cat == RLS_CAT_GOOD);
         led_red   <= (upd_cat == RLS_CAT_POOR);
      end
   end

   // Register reads answer one cycle later
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hr_rd_valid <= 1'b0;
         hr_rd_data  <= `RLS_UNMAPPED_DATA;
      end else begin
         hr_rd_valid <= hr_rd_en;
         if (hr_rd_en) begin
            hr_rd_data <= rd_mux;
         end
      end
   end

   rls_hist_mem #(
      .WIDTH (2),
      .DEPTH (WIN),
      .AW    (AW)
   ) u_hist (
      .clk     (clk),
      .wr_en   (upd_go && !kill),
      .wr_addr (upd_ptr),
      .wr_data (upd_cat),
      .rd_en   (samp_go),
      .rd_addr (ptr),
      .rd_data (old_bits)
   );

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   AST_START: assert property (start |=> survey_active && survey_node == $past(cmd_node[3:0]))
      else $error("survey did not start for the written node");
   AST_NODE_RANGE: assert property (survey_wr && !node_ok && cmd_node != 8'h00 && !running
      |=> !survey_active)
      else $error("node number outside 1 to 15 started a survey");
   AST_STOP: assert property (stop |=> !survey_active ##1 !led_green && !led_amber && !led_red)
      else $error("survey kept running after stop");
   AST_ONE_NODE: assert property (survey_active && $past(survey_active) |-> $stable(survey_node))
      else $error("surveyed node changed without a stop");
   AST_ERR_IGNORED: assert property (running && err_valid && !stop |=> $stable(norm8))
      else $error("error message taken during survey");
   AST_RD_RESULT: assert property (hr_rd_en && running && hr_rd_addr == `RLS_IO_EXC_GOOD
      && !legacy_layout |=> hr_rd_valid && hr_rd_data == $past({exc_b, good_b}))
      else $error("register 8 did not read survey totals");
   AST_LAYOUT7: assert property (hr_rd_en && running && hr_rd_addr == `RLS_IO_POOR_MISSED
      |=> hr_rd_data[7:0] == $past(legacy_layout ? poor_b : miss_b))
      else $error("register 7 byte layout wrong");
   AST_TALLY: assert property (cnt[0] + cnt[1] + cnt[2] + cnt[3] == fill && fill <= WIN_CNT)
      else $error("totals do not add up to the window fill");
   AST_SAVE: assert property (start |=> saved8 == $past(norm8))
      else $error("register 8 not saved at survey start");
   AST_RESTORE: assert property (stop |=> norm8 == $past(saved8))
      else $error("register 8 not restored after survey");
   AST_CLEAR: assert property (start |=> fill == '0 && cnt[RLS_CAT_EXC] == '0)
      else $error("start did not clear the tally");
   AST_LED: assert property (upd_go && running && !kill && upd_cat == RLS_CAT_EXC
      |=> led_green && !led_red)
      else $error("green indicator not lit for excellent sample");

   COV_START_STOP: cover property (start ##[1:1000] stop);
   COV_WINDOW_FULL: cover property (full && upd_go);
   COV_LEGACY_READ: cover property (hr_rd_en && running && legacy_layout);

endmodule

// ### pkg/rls_defs.svh
`ifndef RLS_DEFS_SVH
`define RLS_DEFS_SVH

// Holding register numbers of the gateway
`define RLS_IO_POOR_MISSED    5'h07
`define RLS_IO_EXC_GOOD       5'h08
`define RLS_IO_COMMAND        5'h0F

// Command word layout
`define RLS_CODE_HI           15
`define RLS_CODE_LO           8
`define RLS_DATA_HI           7
`define RLS_DATA_LO           0
`define RLS_CODE_SURVEY       8'h20
`define RLS_NODE_STOP         8'h00
`define RLS_NODE_MAX          8'h0F

// Reset values
`define RLS_CMD_RESET         16'h0000
`define RLS_NORM_RESET        16'h0000
`define RLS_UNMAPPED_DATA     16'h0000

// Sliding window and classification thresholds
`define RLS_WINDOW_LEN        100
`define RLS_EXC_MIN           8'hA0
`define RLS_GOOD_MIN          8'h60

`endif

// ### pkg/rls_pkg.sv
package rls_pkg;

   typedef enum logic [1:0] {
      RLS_CAT_EXC    = 2'h0,
      RLS_CAT_GOOD   = 2'h1,
      RLS_CAT_POOR   = 2'h2,
      RLS_CAT_MISSED = 2'h3
   } rls_cat_t;

   typedef enum logic [1:0] {
      RLS_ST_IDLE = 2'b01,
      RLS_ST_RUN  = 2'b10
   } rls_state_t;

   typedef struct packed {
      logic [4:0]  addr;
      logic [15:0] data;
   } rls_hreg_t;

endpackage

// ### rtl/rls_hist_mem.sv
`timescale 1ns/1ps
module rls_hist_mem #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 100,
   parameter int AW    = $clog2(DEPTH)
) (
   // Clock
   input  wire logic             clk,
   // Write port
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   // Read port
   input  wire logic             rd_en,
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem [DEPTH];

   // Contents need no reset: the fill count decides what is valid
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule

// ### bench/rls_host_model.sv
`timescale 1ns/1ps
`include "rls_defs.svh"
module rls_host_model (
   // Clock
   input  wire logic         clk,
   // Holding register access
   output rls_pkg::rls_hreg_t hr_wr,
   output logic              hr_wr_en,
   output logic              hr_rd_en,
   output logic [4:0]        hr_rd_addr,
   input  wire logic [15:0]  hr_rd_data,
   input  wire logic         hr_rd_valid
);
   import rls_pkg::*;
   initial begin
      hr_wr_en   = 1'b0;
      hr_rd_en   = 1'b0;
      hr_wr      = '0;
      hr_rd_addr = 5'h00;
   end
   // A released bus shows the inverse so stale values never pass
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge clk);
      hr_wr_en = 1'b1;
      hr_wr    = '{addr: a, data: d};
      @(negedge clk);
      hr_wr_en = 1'b0;
      hr_wr    = ~hr_wr;
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
      @(negedge clk);
      hr_rd_en   = 1'b1;
      hr_rd_addr = a;
      @(negedge clk);
      hr_rd_en   = 1'b0;
      hr_rd_addr = ~a;
      v          = hr_rd_valid;
      d          = hr_rd_data;
   endtask
   // Another node only after the running one is stopped
   task automatic survey(input logic [7:0] node);
      wr(`RLS_IO_COMMAND, {`RLS_CODE_SURVEY, `RLS_NODE_STOP});
      wr(`RLS_IO_COMMAND, {`RLS_CODE_SURVEY, node});
   endtask
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
`include "rls_defs.svh"
module tb;
   import rls_pkg::*;
   localparam int WIN = 4;
   logic               clk;
   logic               sys_rst;
   logic               hr_wr_en;
   rls_hreg_t          hr_wr;
   logic               hr_rd_en;
   logic [4:0]         hr_rd_addr;
   logic [15:0]        hr_rd_data;
   logic               hr_rd_valid;
   logic               rssi_valid;
   logic [7:0]         rssi_level;
   logic               interval_end;
   logic               err_valid;
   logic [15:0]        err_code;
   logic               legacy_layout;
   logic               survey_active;
   logic [3:0]         survey_node;
   logic               led_green;
   logic               led_amber;
   logic               led_red;
   int                 fails;
   int                 cmp_count;
   rls_cat_t           q[$];
   logic [7:0]         lv[4] = '{8'hA0, 8'h9F, 8'h60, 8'h5F};

   rls_survey_ctrl #(.WIN(WIN)) DUT (.clk(clk), .sys_rst(sys_rst), .hr_wr_en(hr_wr_en),
      .hr_wr(hr_wr), .hr_rd_en(hr_rd_en), .hr_rd_addr(hr_rd_addr), .hr_rd_data(hr_rd_data),
      .hr_rd_valid(hr_rd_valid), .rssi_valid(rssi_valid), .rssi_level(rssi_level),
      .interval_end(interval_end), .err_valid(err_valid), .err_code(err_code),
      .legacy_layout(legacy_layout), .survey_active(survey_active),
      .survey_node(survey_node), .led_green(led_green), .led_amber(led_amber),
      .led_red(led_red));
   rls_host_model HOST (.clk(clk), .hr_wr(hr_wr), .hr_wr_en(hr_wr_en), .hr_rd_en(hr_rd_en),
      .hr_rd_addr(hr_rd_addr), .hr_rd_data(hr_rd_data), .hr_rd_valid(hr_rd_valid));

   function automatic rls_cat_t cat_of(input logic [7:0] l);
      if (l >= `RLS_EXC_MIN) return RLS_CAT_EXC;
      if (l >= `RLS_GOOD_MIN) return RLS_CAT_GOOD;
      return RLS_CAT_POOR;
   endfunction
   function automatic logic [7:0] tot(input rls_cat_t c);
      logic [7:0] n;
      n = 8'h00;
      foreach (q[i]) if (q[i] == c) n++;
      return n;
   endfunction
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t: saw %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] d;
      logic        v;
      HOST.rd(a, d, v);
      chk({15'h0000, v}, 16'h0001);
      chk(d, exp);
   endtask
   task automatic chktot;
      logic [7:0] p, m, e, g;
      p = tot(RLS_CAT_POOR);
      m = tot(RLS_CAT_MISSED);
      e = tot(RLS_CAT_EXC);
      g = tot(RLS_CAT_GOOD);
      rdchk(`RLS_IO_POOR_MISSED, legacy_layout ? {m, p} : {p, m});
      rdchk(`RLS_IO_EXC_GOOD, legacy_layout ? {g, e} : {e, g});
   endtask
   task automatic err(input logic [15:0] c);
      @(negedge clk);
      err_valid = 1'b1;
      err_code  = c;
      @(negedge clk);
      err_valid = 1'b0;
      err_code  = ~c;
   endtask
   // Two levels per interval; the weaker one must become the sample
   task automatic sample(input logic miss, input logic [7:0] a, input logic [7:0] b);
      rls_cat_t c;
      @(negedge clk);
      rssi_valid = !miss;
      rssi_level = a;
      @(negedge clk);
      interval_end = 1'b1;
      rssi_level   = b;
      @(negedge clk);
      interval_end = 1'b0;
      rssi_valid   = 1'b0;
      rssi_level   = ~b;
      repeat (2) @(negedge clk);
      c = miss ? RLS_CAT_MISSED : cat_of(a < b ? a : b);
      q.push_back(c);
      if (q.size() > WIN) void'(q.pop_front());
      chk({13'h0000, led_green, led_amber, led_red},
          {13'h0000, c == RLS_CAT_EXC, c == RLS_CAT_GOOD, c == RLS_CAT_POOR});
      chktot();
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;
      fails++;
      conclude();
   end
   initial begin
      sys_rst = 1'b1;
      {rssi_valid, rssi_level, interval_end, err_valid, err_code, legacy_layout} = '0;
      void'($urandom(91995));
      repeat (12) @(negedge clk);
      sys_rst = 1'b0;
      foreach (lv[i]) rdchk(5'(i * 4 + 3), 16'h0000);
      chk({8'h00, survey_active, survey_node, led_green, led_amber, led_red}, 16'h0000);
      $display("test reset done");
      err(16'h1234);
      HOST.wr(`RLS_IO_POOR_MISSED, 16'h5555);
      HOST.survey(8'h10);
      chk({15'h0000, survey_active}, 16'h0000);
      HOST.survey(8'h02);
      chk({11'h000, survey_active, survey_node}, 16'h0012);
      chktot();
      err(16'hBEEF);
      chktot();
      $display("test start done");
      foreach (lv[i]) sample(1'b0, lv[i], 8'hFF);
      sample(1'b0, 8'hB0, 8'h50);
      sample(1'b1, 8'h00, 8'h00);
      repeat (10) sample($urandom_range(4) == 0, 8'($urandom), 8'($urandom));
      legacy_layout = 1'b1;
      chktot();
      legacy_layout = 1'b0;
      $display("test tally done");
      // Writes to 7 and 8 are refused while surveying; other codes only land in 15
      HOST.wr(`RLS_IO_POOR_MISSED, 16'hAAAA);
      HOST.wr(`RLS_IO_EXC_GOOD, 16'hBBBB);
      HOST.wr(`RLS_IO_COMMAND, 16'h0402);
      chktot();
      rdchk(`RLS_IO_COMMAND, 16'h0402);
      HOST.wr(`RLS_IO_COMMAND, 16'h2005);
      chk({11'h000, survey_active, survey_node}, 16'h0012);
      HOST.wr(`RLS_IO_COMMAND, 16'h2000);
      chk({11'h000, survey_active, survey_node}, 16'h0000);
      chk({13'h0000, led_green, led_amber, led_red}, 16'h0000);
      rdchk(`RLS_IO_EXC_GOOD, 16'h1234);
      rdchk(`RLS_IO_POOR_MISSED, 16'h5555);
      rdchk(`RLS_IO_COMMAND, 16'h2000);
      HOST.survey(8'h0F);
      q.delete();
      chk({11'h000, survey_active, survey_node}, 16'h001F);
      chktot();
      $display("test stop done");
      // Reset in mid-survey must leave everything idle and cleared
      @(negedge clk);
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      chk({8'h00, survey_active, survey_node, led_green, led_amber, led_red}, 16'h0000);
      rdchk(`RLS_IO_EXC_GOOD, 16'h0000);
      rdchk(`RLS_IO_COMMAND, 16'h0000);
      $display("test rerun reset done");
      conclude();
   end
endmodule
